/* File: design/txdh_align_if.sv */
interface txdh_align_if;
  logic        load;
  logic [31:0] word;
  logic [1:0]  off;
  logic [2:0]  cnt;
  logic        sof;
  logic        eof;
  logic        busy;

  modport ctl (output load, word, off, cnt, sof, eof, input busy);
  modport aln (input load, word, off, cnt, sof, eof, output busy);
endinterface

/* File: design/txdh_byte_out.sv */
module txdh_byte_out
  import txdh_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  txdh_align_if.aln       a,
  input  wire logic       tx_ready,
  output logic      [7:0] tx_data_ff,
  output logic            tx_valid_ff,
  output logic            tx_first_ff,
  output logic            tx_last_ff
);

  logic [31:0] word_ff;
  logic [1:0]  idx_ff;
  logic [2:0]  left_ff;
  logic        eof_ff;
  logic        busy_ff;

  assign a.busy = busy_ff;

  // shift bytes of one word out from any start lane
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      word_ff     <= 32'h0000_0000;
      idx_ff      <= 2'h0;
      left_ff     <= 3'h0;
      eof_ff      <= 1'b0;
      busy_ff     <= 1'b0;
      tx_data_ff  <= 8'h00;
      tx_valid_ff <= 1'b0;
      tx_first_ff <= 1'b0;
      tx_last_ff  <= 1'b0;
    end
    else if (a.load)
    begin
      word_ff     <= a.word;
      tx_data_ff  <= a.word[{a.off, 3'b000} +: 8];
      idx_ff      <= a.off + 2'h1;
      left_ff     <= a.cnt - 3'h1;
      eof_ff      <= a.eof;
      busy_ff     <= 1'b1;
      tx_valid_ff <= 1'b1;
      tx_first_ff <= a.sof;
      tx_last_ff  <= a.eof && (a.cnt == 3'h1);
    end
    else if (tx_valid_ff && tx_ready)
    begin
      if (left_ff != 3'h0)
      begin
        tx_data_ff  <= word_ff[{idx_ff, 3'b000} +: 8];
        idx_ff      <= idx_ff + 2'h1;
        left_ff     <= left_ff - 3'h1;
        tx_first_ff <= 1'b0;
        tx_last_ff  <= eof_ff && (left_ff == 3'h1);
      end
      else
      begin
        // word drained: control may load the next one
        busy_ff     <= 1'b0;
        tx_valid_ff <= 1'b0;
        tx_first_ff <= 1'b0;
        tx_last_ff  <= 1'b0;
      end
    end
  end

endmodule

/* File: design/txdh_pkg.sv */
package txdh_pkg;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_BASE   = 8'h04;
  localparam logic [7:0] REG_CUR    = 8'h08;
  localparam logic [7:0] REG_ISTAT  = 8'h0C;
  localparam logic [7:0] REG_IMASK  = 8'h10;
  localparam logic [7:0] REG_STATE  = 8'h14;

  // control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_POLL   = 1;

  // interrupt status fields
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_UNAV  = 1;
  localparam int IRQ_ERR   = 2;
  localparam int IRQ_W     = 3;

  // descriptor word offsets, descriptor stride
  localparam logic [31:0] DESC_W0     = 32'h0000_0000;
  localparam logic [31:0] DESC_W1     = 32'h0000_0004;
  localparam logic [31:0] DESC_W2     = 32'h0000_0008;
  localparam logic [31:0] DESC_W3     = 32'h0000_000C;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;

  // tx_desc_word0 fields
  localparam int W0_OWN    = 31;
  localparam int W0_URC_HI = 23;
  localparam int W0_URC_LO = 22;
  localparam int W0_ERSUM  = 15;
  localparam int W0_JABT   = 14;
  localparam int W0_CDROP  = 11;
  localparam int W0_NC     = 10;
  localparam int W0_LCOL   = 9;
  localparam int W0_XCOL   = 8;
  localparam int W0_HBF    = 7;
  localparam int W0_COL_HI = 6;
  localparam int W0_COL_LO = 3;
  localparam int W0_URERR  = 1;
  localparam int W0_DEFER  = 0;

  // tx_desc_word1 fields
  localparam int W1_IRQ    = 31;
  localparam int W1_LAST   = 30;
  localparam int W1_FIRST  = 29;
  localparam int W1_NOCRC  = 26;
  localparam int W1_WRAP   = 25;
  localparam int W1_CHAIN  = 24;
  localparam int W1_NOPAD  = 23;
  localparam int W1_BS2_HI = 21;
  localparam int W1_BS2_LO = 11;
  localparam int W1_BS1_HI = 10;
  localparam int W1_BS1_LO = 0;
  localparam int LEN_W     = 11;

  // status bits of one frame, as reported by the mac
  typedef struct packed {
    logic [1:0] underrun_count;
    logic       jabber_timeout;
    logic       carrier_dropped;
    logic       carrier_absent;
    logic       late_collision;
    logic       excess_collision;
    logic       heartbeat_fail;
    logic [3:0] collision_count;
    logic       underrun_error;
    logic       tx_postponed;
  } txdh_mac_stat_t;

endpackage

/* File: design/txdh_top.sv */
module txdh_top
  import txdh_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  output logic             tx_first,
  output logic             tx_last,
  output logic             tx_no_crc,
  output logic             tx_no_pad,
  input  wire logic        tx_ready,
  input  wire logic        mac_done,
  input  wire txdh_mac_stat_t mac_stat,
  output logic             irq
);

  typedef enum logic [2:0] {
    S_IDLE, S_RD, S_CHECK, S_BUF_SEL, S_BUF_RD, S_BUF_WAIT, S_WAIT_MAC, S_WB
  } txdh_state_t;

  txdh_state_t    state_ff;
  logic [31:0]    prdata_ff;
  logic           pready_ff;
  logic           pslverr_ff;
  logic           enable_ff;
  logic           poll_ff;
  logic [31:0]    base_ff;
  logic [31:0]    cur_ff;
  logic [IRQ_W-1:0] istat_ff;
  logic [IRQ_W-1:0] imask_ff;
  logic [IRQ_W-1:0] irq_set;
  logic           irq_ff;
  logic           suspended_ff;
  logic [31:0]    w0_ff;
  logic [31:0]    w1_ff;
  logic [31:0]    w2_ff;
  logic [31:0]    w3_ff;
  logic [1:0]     widx_ff;
  logic           sel_ff;
  logic [31:0]    ptr_ff;
  logic [LEN_W-1:0] rem_ff;
  logic           sof_pend_ff;
  logic [31:0]    stat_word_ff;
  logic           no_crc_ff;
  logic           no_pad_ff;
  logic           mem_req_ff;
  logic           mem_we_ff;
  logic [31:0]    mem_addr_ff;
  logic [31:0]    mem_wdata_ff;
  logic           wr_done;
  logic           acc;
  logic           chain_eff;
  logic [2:0]     avail;
  logic [2:0]     nbytes;
  logic           desc_end;

  txdh_align_if u_if ();

  txdh_byte_out u_out (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .a           (u_if.aln),
    .tx_ready    (tx_ready),
    .tx_data_ff  (tx_data),
    .tx_valid_ff (tx_valid),
    .tx_first_ff (tx_first),
    .tx_last_ff  (tx_last)
  );

  // error summary is the or of the six fault bits
  function automatic logic err_sum(input txdh_mac_stat_t s);
    err_sum = s.underrun_error | s.excess_collision | s.late_collision
            | s.carrier_absent | s.carrier_dropped | s.jabber_timeout;
  endfunction

  // build tx_desc_word0 for write-back; ownership always clear
  function automatic logic [31:0] pack_w0(input txdh_mac_stat_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[W0_URC_HI:W0_URC_LO] = s.underrun_count;
    w[W0_ERSUM] = err_sum(s);
    w[W0_JABT] = s.jabber_timeout;
    w[W0_CDROP] = s.carrier_dropped;
    w[W0_NC] = s.carrier_absent;
    w[W0_LCOL] = s.late_collision;
    w[W0_XCOL] = s.excess_collision;
    w[W0_HBF] = s.heartbeat_fail;
    w[W0_COL_HI:W0_COL_LO] = s.collision_count;
    w[W0_URERR] = s.underrun_error;
    w[W0_DEFER] = s.tx_postponed;
    pack_w0 = w;
  endfunction

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign mem_req   = mem_req_ff;
  assign mem_we    = mem_we_ff;
  assign mem_addr  = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign tx_no_crc = no_crc_ff;
  assign tx_no_pad = no_pad_ff;
  assign irq       = irq_ff;

  // wrap wins, so the chain link only counts without it
  assign chain_eff = w1_ff[W1_CHAIN] && !w1_ff[W1_WRAP];
  assign avail     = 3'h4 - {1'b0, ptr_ff[1:0]};
  assign nbytes    = (rem_ff < LEN_W'(avail)) ? rem_ff[2:0] : avail;
  // last chunk of this descriptor's data
  assign desc_end  = (rem_ff == LEN_W'(nbytes))
                  && (sel_ff || chain_eff
                      || w1_ff[W1_BS2_HI:W1_BS2_LO] == '0);
  assign acc       = psel && penable && pready_ff;
  assign wr_done   = acc && pwrite;

  // apb: one wait state, so prdata always comes from a flop
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (psel && penable && !pready_ff)
    begin
      pready_ff  <= 1'b1;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      unique case (paddr[7:0])
        REG_CTRL:  prdata_ff[CTRL_ENABLE] <= enable_ff;
        REG_BASE:  prdata_ff <= base_ff;
        REG_CUR:   prdata_ff <= cur_ff;
        REG_ISTAT: prdata_ff[IRQ_W-1:0] <= istat_ff;
        REG_IMASK: prdata_ff[IRQ_W-1:0] <= imask_ff;
        REG_STATE: prdata_ff[1:0] <= {suspended_ff, state_ff != S_IDLE};
        default:   pslverr_ff <= 1'b1;
      endcase
      if (paddr[31:8] != 24'h00_0000)
        pslverr_ff <= 1'b1;
    end
    else
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // software control registers; writes land on the ready edge
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      enable_ff <= 1'b0;
      poll_ff   <= 1'b0;
      base_ff   <= 32'h0000_0000;
      imask_ff  <= '0;
    end
    else
    begin
      poll_ff <= 1'b0;
      if (wr_done && !pslverr_ff)
      begin
        unique case (paddr[7:0])
          REG_CTRL:
          begin
            enable_ff <= pwdata[CTRL_ENABLE];
            poll_ff   <= pwdata[CTRL_POLL];
          end
          REG_BASE:  base_ff  <= {pwdata[31:2], 2'b00};
          REG_IMASK: imask_ff <= pwdata[IRQ_W-1:0];
          default:   ;
        endcase
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      istat_ff <= '0;
      irq_ff   <= 1'b0;
    end
    else
    begin
      if (wr_done && !pslverr_ff && paddr[7:0] == REG_ISTAT)
        istat_ff <= (istat_ff & ~pwdata[IRQ_W-1:0]) | irq_set;
      else
        istat_ff <= istat_ff | irq_set;
      irq_ff <= |((istat_ff | irq_set) & imask_ff);
    end
  end

  // event decode from the descriptor engine
  always_comb
  begin
    irq_set = '0;
    if (state_ff == S_CHECK && !w0_ff[W0_OWN])
      irq_set[IRQ_UNAV] = 1'b1;
    if (state_ff == S_WB && mem_ack && mem_req_ff)
    begin
      irq_set[IRQ_DONE] = w1_ff[W1_IRQ];
      irq_set[IRQ_ERR]  = stat_word_ff[W0_ERSUM];
    end
  end

  // descriptor engine
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_ff     <= S_IDLE;
      cur_ff       <= 32'h0000_0000;
      suspended_ff <= 1'b0;
      w0_ff        <= 32'h0000_0000;
      w1_ff        <= 32'h0000_0000;
      w2_ff        <= 32'h0000_0000;
      w3_ff        <= 32'h0000_0000;
      widx_ff      <= 2'h0;
      sel_ff       <= 1'b0;
      ptr_ff       <= 32'h0000_0000;
      rem_ff       <= '0;
      sof_pend_ff  <= 1'b0;
      stat_word_ff <= 32'h0000_0000;
      no_crc_ff    <= 1'b0;
      no_pad_ff    <= 1'b0;
      mem_req_ff   <= 1'b0;
      mem_we_ff    <= 1'b0;
      mem_addr_ff  <= 32'h0000_0000;
      mem_wdata_ff <= 32'h0000_0000;
      u_if.load    <= 1'b0;
      u_if.word    <= 32'h0000_0000;
      u_if.off     <= 2'h0;
      u_if.cnt     <= 3'h0;
      u_if.sof     <= 1'b0;
      u_if.eof     <= 1'b0;
    end
    else
    begin
      u_if.load <= 1'b0;
      // a refused write must not move the descriptor pointer
      if (wr_done && !pslverr_ff && paddr[7:0] == REG_BASE
          && state_ff == S_IDLE)
        cur_ff <= {pwdata[31:2], 2'b00};
      unique case (state_ff)
        S_IDLE:
        begin
          if (poll_ff)
            suspended_ff <= 1'b0;
          if (enable_ff && (poll_ff || !suspended_ff))
          begin
            widx_ff  <= 2'h0;
            state_ff <= S_RD;
          end
        end
        // fetch the four descriptor words in turn
        S_RD:
        begin
          if (!mem_req_ff)
          begin
            mem_req_ff  <= 1'b1;
            mem_we_ff   <= 1'b0;
            mem_addr_ff <= cur_ff + {28'h000_0000, widx_ff, 2'b00};
          end
          else if (mem_ack)
          begin
            mem_req_ff <= 1'b0;
            unique case (widx_ff)
              2'h0: w0_ff <= mem_rdata;
              2'h1: w1_ff <= mem_rdata;
              2'h2: w2_ff <= mem_rdata;
              2'h3: w3_ff <= mem_rdata;
            endcase
            widx_ff <= widx_ff + 2'h1;
            if (widx_ff == 2'h3)
              state_ff <= S_CHECK;
          end
        end
        S_CHECK:
        begin
          if (!w0_ff[W0_OWN])
          begin
            suspended_ff <= 1'b1;
            state_ff     <= S_IDLE;
          end
          else
          begin
            // owned by the device: start on buffer 1
            sel_ff   <= 1'b0;
            ptr_ff   <= w2_ff;
            rem_ff   <= w1_ff[W1_BS1_HI:W1_BS1_LO];
            state_ff <= S_BUF_SEL;
            if (w1_ff[W1_FIRST])
            begin
              sof_pend_ff <= 1'b1;
              no_crc_ff   <= w1_ff[W1_NOCRC];
              no_pad_ff   <= w1_ff[W1_NOPAD];
            end
          end
        end
        S_BUF_SEL:
        begin
          if (rem_ff != '0)
            state_ff <= S_BUF_RD;
          else if (!sel_ff && !chain_eff)
          begin
            sel_ff <= 1'b1;
            ptr_ff <= w3_ff;
            rem_ff <= w1_ff[W1_BS2_HI:W1_BS2_LO];
          end
          else if (w1_ff[W1_LAST])
            state_ff <= S_WAIT_MAC;
          else
          begin
            stat_word_ff <= 32'h0000_0000;
            state_ff     <= S_WB;
          end
        end
        // aligned word read, lanes picked by the low pointer bits
        S_BUF_RD:
        begin
          if (!mem_req_ff)
          begin
            mem_req_ff  <= 1'b1;
            mem_we_ff   <= 1'b0;
            mem_addr_ff <= {ptr_ff[31:2], 2'b00};
          end
          else if (mem_ack)
          begin
            mem_req_ff  <= 1'b0;
            u_if.load   <= 1'b1;
            u_if.word   <= mem_rdata;
            u_if.off    <= ptr_ff[1:0];
            u_if.cnt    <= nbytes;
            u_if.sof    <= sof_pend_ff;
            u_if.eof    <= w1_ff[W1_LAST] && desc_end;
            sof_pend_ff <= 1'b0;
            ptr_ff      <= ptr_ff + {29'h0000_0000, nbytes};
            rem_ff      <= rem_ff - LEN_W'(nbytes);
            state_ff    <= S_BUF_WAIT;
          end
        end
        S_BUF_WAIT:
        begin
          if (!u_if.load && !u_if.busy)
            state_ff <= S_BUF_SEL;
        end
        // status comes only after the frame's final segment
        S_WAIT_MAC:
        begin
          if (mac_done)
          begin
            stat_word_ff <= pack_w0(mac_stat);
            state_ff     <= S_WB;
          end
        end
        S_WB:
        begin
          if (!mem_req_ff)
          begin
            mem_req_ff   <= 1'b1;
            mem_we_ff    <= 1'b1;
            mem_addr_ff  <= cur_ff + DESC_W0;
            mem_wdata_ff <= stat_word_ff;
          end
          else if (mem_ack)
          begin
            mem_req_ff <= 1'b0;
            mem_we_ff  <= 1'b0;
            widx_ff    <= 2'h0;
            state_ff   <= enable_ff ? S_RD : S_IDLE;
            if (w1_ff[W1_WRAP])
              cur_ff <= base_ff;
            else if (chain_eff)
              cur_ff <= {w3_ff[31:2], 2'b00};
            else
              cur_ff <= cur_ff + DESC_STRIDE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

endmodule

/* File: test/txdh_host_mem.sv */
module txdh_host_mem
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] m [0:255]; // rings kept on longword boundaries
  logic [31:0] last_rd;
  int          wt;
  int          lim;

  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
  end

  // answers after 0..3 wait cycles; data bus toggles outside ack
  always @(posedge clk_sys)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (reset)
    begin
      wt <= 0;
      lim <= 0;
    end
    else if (mem_req && !mem_ack)
    begin
      if (wt < lim)
        wt <= wt + 1;
      else
      begin
        mem_ack <= 1'b1;
        wt <= 0;
        lim <= $urandom % 4;
        if (mem_we)
          m[mem_addr[9:2]] <= mem_wdata;
        else
        begin
          mem_rdata <= m[mem_addr[9:2]];
          last_rd <= mem_addr;
        end
      end
    end
  end
endmodule

/* File: test/txdh_top_sva.sv */
module txdh_top_sva
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_first,
  input wire logic        tx_last,
  input wire logic        tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // access phase still waiting
  sequence apb_acc;
    psel && penable && !pready;
  endsequence

  // memory request not yet taken
  sequence mem_wait;
    mem_req && !mem_ack;
  endsequence

  apb_answer_a: assert property (apb_acc |=> pready)
    else $error("apb access not answered");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  apb_refuse_a: assert property (pready && paddr[31:8] != 0 |-> pslverr)
    else $error("far address not refused");
  mem_hold_a: assert property (mem_wait |=> mem_req &&
    $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed while waiting");
  mem_drop_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request not dropped");
  mem_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
    else $error("unaligned memory word address");
  wb_own_a: assert property (mem_req && mem_we |-> !mem_wdata[31])
    else $error("write-back keeps ownership");
  wb_summary_a: assert property (mem_req && mem_we |->
    mem_wdata[15] == (mem_wdata[14] | (|mem_wdata[11:8]) | mem_wdata[1]))
    else $error("error summary wrong");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_data) && $stable({tx_first, tx_last}))
    else $error("byte changed before taken");
  tx_flag_a: assert property (tx_first || tx_last |-> tx_valid)
    else $error("frame flag without valid");
endmodule

bind txdh_top txdh_top_sva u_sva (.clk_sys, .reset, .psel, .penable,
  .paddr, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata,
  .mem_ack, .tx_data, .tx_valid, .tx_first, .tx_last, .tx_ready);

/* File: test/txdh_top_tb.sv */
module txdh_top_tb import txdh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic           clk_sys, reset, psel, penable, pwrite, pready, pslverr;
  logic           mem_req, mem_we, mem_ack, tx_valid, tx_first, tx_last;
  logic           tx_no_crc, tx_no_pad, tx_ready, mac_done, irq, er;
  logic           nocrc, nopad;
  logic [31:0]    paddr, pwdata, prdata, mem_addr, mem_wdata, mem_rdata;
  logic [31:0]    rd, ew;
  logic [7:0]     tx_data;
  logic [2:0]     msk;
  logic [9:0]     got [$];
  logic [7:0]     exp_b [$];
  txdh_mac_stat_t mac_stat, s;
  int             errors, n_tests, cyc;

  txdh_top u_dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .tx_data, .tx_valid, .tx_first,
    .tx_last, .tx_no_crc, .tx_no_pad, .tx_ready, .mac_done, .mac_stat,
    .irq);
  txdh_host_mem u_mem (.clk_sys, .reset, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata);

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask

  task stop_test;
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer; held until pready is seen
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] exp_w0(input txdh_mac_stat_t t);
    logic es;
    es = t.underrun_error | t.excess_collision | t.late_collision |
      t.carrier_absent | t.carrier_dropped | t.jabber_timeout;
    return {8'h0, t.underrun_count, 6'h0, es, t.jabber_timeout, 2'h0,
      t.carrier_dropped, t.carrier_absent, t.late_collision,
      t.excess_collision, t.heartbeat_fail, t.collision_count, 1'b0,
      t.underrun_error, t.tx_postponed};
  endfunction

  // expected bytes, little-endian lanes from any start address
  task put(input logic [31:0] p, input int n);
    logic [31:0] w;
    for (int i = 0; i < n; i++)
    begin
      w = u_mem.m[(p + i) >> 2];
      exp_b.push_back(w[8 * ((p + i) % 4) +: 8]);
    end
  endtask

  // record every byte the mac takes
  always @(posedge clk_sys)
    if (!reset && tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      got.push_back({tx_last, tx_first, tx_data});
      if (tx_first)
      begin
        nocrc = tx_no_crc;
        nopad = tx_no_pad;
      end
    end

  // mac stalls at random to exercise hold
  always @(posedge clk_sys)
    tx_ready <= ($urandom % 4) != 0;

  // hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      errors++;
      stop_test();
    end
  end

  initial
  begin
    {psel, penable, pwrite, mac_done, tx_ready} = 5'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    mac_stat = '0;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    reset = 1'b1;
    void'($urandom(19));
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    apb(0, REG_IMASK, 32'h0);
    chk(rd, 32'h0);
    apb(1, 32'h0000_1000, 32'hFFFF_FFFF);
    apb(0, 32'h0000_1000, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1, REG_BASE, 32'h0000_0100);
    apb(0, REG_CUR, 32'h0);
    chk(rd, 32'h0000_0100);
    for (int it = 0; it < 3; it++)
    begin
      for (int i = 8'h80; i < 8'hC8; i++)
        u_mem.m[i] = $urandom;
      // chained first segment, then wrap plus chain final segment
      u_mem.m[8'h40] = 32'h8000_0000;
      u_mem.m[8'h41] = 32'h2100_0005 | {5'h0, it[0], 2'h0, it[1], 23'h0};
      u_mem.m[8'h42] = 32'h0000_0201;
      u_mem.m[8'h43] = 32'h0000_0140;
      u_mem.m[8'h50] = 32'h8000_0000;
      u_mem.m[8'h51] = 32'hC300_1003;
      u_mem.m[8'h52] = 32'h0000_0302;
      u_mem.m[8'h53] = 32'h0000_0311;
      exp_b = {};
      got = {};
      put(32'h201, 5);
      put(32'h302, 3);
      put(32'h311, 2);
      rd = $urandom;
      s = rd[$bits(txdh_mac_stat_t)-1:0];
      if (it == 0)
        {s.jabber_timeout, s.carrier_dropped, s.carrier_absent,
          s.late_collision, s.excess_collision, s.underrun_error} = 6'h0;
      ew = exp_w0(s);
      msk = (it == 2) ? 3'h0 : 3'h5;
      apb(1, REG_IMASK, {29'h0, msk});
      apb(1, REG_CTRL, (it == 0) ? 32'h1 : 32'h3);
      while (got.size() < 10)
        @(posedge clk_sys);
      // engine only listens once it has settled after the last byte
      repeat (3) @(posedge clk_sys);
      mac_done <= 1'b1;
      mac_stat <= s;
      @(posedge clk_sys);
      mac_done <= 1'b0;
      do apb(0, REG_STATE, 32'h0); while (rd[1] !== 1'b1);
      chk(got.size(), 10);
      foreach (exp_b[i])
        chk({22'h0, got[i]}, {22'h0, i == 9, i == 0, exp_b[i]});
      chk({31'h0, nocrc}, {31'h0, it[0]});
      chk({31'h0, nopad}, {31'h0, it[1]});
      chk(u_mem.m[8'h40], 32'h0);
      chk(u_mem.m[8'h50], ew);
      // wrap refetches all four words of the base descriptor
      chk(u_mem.last_rd, 32'h0000_010C);
      apb(0, REG_CUR, 32'h0);
      chk(rd, 32'h0000_0100);
      apb(0, REG_ISTAT, 32'h0);
      chk(rd, {29'h0, ew[15], 2'b11});
      chk({31'h0, irq}, {31'h0, |({ew[15], 2'b11} & msk)});
      apb(1, REG_ISTAT, 32'h7);
      apb(0, REG_ISTAT, 32'h0);
      chk(rd, 32'h0);
      @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
    end
    stop_test();
  end
endmodule
